/* sfw_pkg.sv */
package sfw_pkg;
  // Register map.
  localparam logic [3:0] SFW_CTRL_ADDR   = 4'h0; // watchdog_control_reg
  localparam logic [3:0] SFW_OPT_ADDR    = 4'h4; // option settings
  localparam logic [3:0] SFW_STAT_ADDR   = 4'h8; // status
  localparam int         SFW_ACT_BIT     = 7;
  localparam int         SFW_MSB_BIT     = 6;
  localparam int         SFW_OPT_HW_BIT  = 0;
  localparam int         SFW_OPT_HLT_BIT = 1;
  localparam logic [6:0] SFW_CNT_RESET   = 7'h7F;
  localparam logic [6:0] SFW_CNT_TRIP    = 7'h40;
  localparam logic [1:0] SFW_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SFW_RESP_SLVERR = 2'h2;
  // Timing.
  localparam int         SFW_PRESCALE    = 16384;
  localparam int         SFW_CLK_MHZ     = 40;
  localparam int         SFW_RST_NS      = 500;
  localparam int         SFW_RST_CYC     = (SFW_RST_NS * SFW_CLK_MHZ) / 1000;
  localparam int         SFW_WAKE_SHORT  = 256;
  localparam int         SFW_WAKE_LONG   = 4096;
endpackage

/* sfw_pulse.sv */
`timescale 1ns/1ps
// Stretches a one-cycle trigger into a low-active reset pulse of fixed length.
module sfw_pulse #(
  parameter int LEN = 20
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic trig,
  output logic      rst_out_n,
  output logic      busy
);
  typedef struct packed {
    logic [15:0] cnt;
  } sfw_pulse_st_t;
  sfw_pulse_st_t st_ff;
  sfw_pulse_st_t nxt_st;

  // Count down while the pulse is active; a new trigger restarts it.
  // fixed pulse length
  always_comb begin
    nxt_st = st_ff;
    if (trig) begin
      nxt_st.cnt = 16'(LEN);
    end else if (st_ff.cnt != 16'h0000) begin
      nxt_st.cnt = st_ff.cnt - 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy      = (st_ff.cnt != 16'h0000);
  assign rst_out_n = ~busy;

  a_pulse_len: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(busy) |-> busy [*8]) else $error("reset pulse too short");
endmodule

/* sfw_watchdog.sv */
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module sfw_watchdog
  import sfw_pkg::*;
#(
  parameter int PRESCALE = sfw_pkg::SFW_PRESCALE,
  parameter int WAKE_SHORT = sfw_pkg::SFW_WAKE_SHORT,
  parameter int WAKE_LONG = sfw_pkg::SFW_WAKE_LONG
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        halt_req,
  input  wire logic        wake_irq,
  input  wire logic        wake_long_sel,
  output logic             halt_enter,
  output logic             dev_reset_n
);
  import sfw_pkg::*;

  typedef struct packed {
    logic [15:0] pre;
    logic [6:0]  cnt;
    logic        act;
    logic        opt_hw;
    logic        opt_hlt;
    logic        opt_lock;
    logic        halted;
    logic        frozen;
    logic [12:0] wake;
    logic        trig;
    logic        halt_out;
    logic        aw_got;
    logic        w_got;
    logic [3:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sfw_st_t;

  sfw_st_t st_ff;
  sfw_st_t nxt_st;
  logic    pulse_busy;
  logic    pre_tick;
  logic    wr_go;
  logic    rd_go;

  ////////////////////////////////////////////////////////////////////////
  // Bus handshakes: one outstanding write and one outstanding read.
  assign s_axi_awready = ~st_ff.aw_got & ~st_ff.bvalid;
  assign s_axi_wready  = ~st_ff.w_got & ~st_ff.bvalid;
  assign s_axi_arready = ~st_ff.rvalid;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;
  assign halt_enter    = st_ff.halt_out;
  assign wr_go         = st_ff.aw_got & st_ff.w_got;
  assign rd_go         = s_axi_arvalid & s_axi_arready;
  assign pre_tick      = (st_ff.pre == 16'(PRESCALE - 1));

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic for counter, options, halt and bus.
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.trig = 1'b0;
    nxt_st.pre = pre_tick ? 16'h0000 : st_ff.pre + 16'h0001;
    if (pre_tick && !st_ff.frozen) begin
      nxt_st.cnt = st_ff.cnt - 7'h01;
      if (st_ff.halted) begin
        nxt_st.frozen = 1'b1;
      end
      if (st_ff.act && st_ff.cnt == SFW_CNT_TRIP) begin
        nxt_st.trig = 1'b1;
      end
    end
    if (st_ff.halted && wake_irq) begin
      nxt_st.halted = 1'b0;
      nxt_st.wake   = wake_long_sel ? 13'(WAKE_LONG) : 13'(WAKE_SHORT);
    end else if (st_ff.wake != 13'h0000) begin
      nxt_st.wake = st_ff.wake - 13'h0001;
      // A freeze that lands on the release edge wins, so halt is never lost.
      if (st_ff.wake == 13'h0001 && !(pre_tick && st_ff.halted)) begin
        nxt_st.frozen = 1'b0;
      end
    end
    nxt_st.halt_out = 1'b0;
    if (halt_req && !st_ff.halted) begin
      if (st_ff.act || st_ff.opt_hlt) begin
        nxt_st.trig = 1'b1;
      end else begin
        nxt_st.halted   = 1'b1;
        nxt_st.halt_out = 1'b1;
      end
    end
    // Address and data may arrive in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (wr_go) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = SFW_RESP_OKAY;
      case (st_ff.awaddr)
        SFW_CTRL_ADDR: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.cnt = st_ff.wdata[6:0];
            nxt_st.act = st_ff.act | st_ff.wdata[SFW_ACT_BIT];
            if (st_ff.wdata[SFW_ACT_BIT] && !st_ff.wdata[SFW_MSB_BIT]) begin
              nxt_st.trig = 1'b1;
            end
          end
        end
        SFW_OPT_ADDR: begin
          // Options behave as write-once until reset, which clears them and the lock.
          if (st_ff.wstrb[0] && !st_ff.opt_lock) begin
            nxt_st.opt_hw   = st_ff.wdata[SFW_OPT_HW_BIT];
            nxt_st.opt_hlt  = st_ff.wdata[SFW_OPT_HLT_BIT];
            nxt_st.opt_lock = 1'b1;
            if (st_ff.wdata[SFW_OPT_HW_BIT]) begin
              nxt_st.act = 1'b1;
            end
          end
        end
        SFW_STAT_ADDR: nxt_st.bresp = SFW_RESP_OKAY;
        default: nxt_st.bresp = SFW_RESP_SLVERR;
      endcase
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (rd_go) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = SFW_RESP_OKAY;
      case (s_axi_araddr)
        SFW_CTRL_ADDR: nxt_st.rdata = {24'h000000, st_ff.act, st_ff.cnt};
        SFW_OPT_ADDR:  nxt_st.rdata = {29'h00000000, st_ff.opt_lock, st_ff.opt_hlt,
                                       st_ff.opt_hw};
        SFW_STAT_ADDR: nxt_st.rdata = {30'h00000000, st_ff.frozen, st_ff.halted};
        default: begin
          nxt_st.rdata = 32'h00000000;
          nxt_st.rresp = SFW_RESP_SLVERR;
        end
      endcase
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; the bus reset also represents device reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff     <= '0;
      st_ff.cnt <= SFW_CNT_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // The reset pulse is a separate stretcher so the count keeps its own timing.
  sfw_pulse #(
    .LEN (SFW_RST_CYC)
  ) sfw_pulse_inst (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .trig      (st_ff.trig),
    .rst_out_n (dev_reset_n),
    .busy      (pulse_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  a_trip_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    (pre_tick && !st_ff.frozen && st_ff.act && st_ff.cnt == SFW_CNT_TRIP)
    |=> ##1 !dev_reset_n) else $error("no reset on count trip");
  a_act_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff.act |=> st_ff.act) else $error("activate cleared");
  a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
    (pre_tick && !st_ff.frozen && !wr_go) |=> st_ff.cnt == $past(st_ff.cnt) - 7'h01)
    else $error("count did not step");
  a_hold_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pre_tick && !wr_go) |=> st_ff.cnt == $past(st_ff.cnt))
    else $error("count moved off tick");
  // The edge that leaves reset also clears the prescaler, so it is not a normal step.
  a_pre_free: assert property (@(posedge aclk) disable iff (!aresetn)
    (aresetn && !pre_tick) |=> st_ff.pre == $past(st_ff.pre) + 16'h0001)
    else $error("prescaler disturbed");
  a_sw_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && st_ff.awaddr == SFW_CTRL_ADDR && st_ff.wstrb[0] &&
     st_ff.wdata[7] && !st_ff.wdata[6]) |=> ##1 !dev_reset_n)
    else $error("software reset missing");
  a_halt_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    (halt_req && !st_ff.halted && st_ff.act) |=> !halt_enter ##1 !dev_reset_n)
    else $error("halt did not reset");
  a_frozen_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff.frozen && !wr_go) |=> st_ff.cnt == $past(st_ff.cnt))
    else $error("frozen count moved");
  c_trip: cover property (@(posedge aclk) st_ff.trig && st_ff.act);
  c_pulse: cover property (@(posedge aclk) $rose(pulse_busy) && st_ff.act);
  c_halt: cover property (@(posedge aclk) halt_enter);
  c_wake: cover property (@(posedge aclk) st_ff.wake == 13'h0001);
endmodule

/* sfw_watchdog_tb.sv */
`timescale 1ns/1ps
module sfw_watchdog_tb;
  import sfw_pkg::*;
  localparam int P = 16;
  logic        aclk, aresetn, awv, wv, br, arv, rr, awr, wr_rdy, bv, arr, rv;
  logic        halt_req, wake_irq, wls, hen, drn;
  logic [3:0]  awa, ara;
  logic [31:0] wd, rd, d, d1, d2;
  logic [1:0]  bresp, rresp, r;
  int          n_mismatch, compares, cyc, c0, t, w, k;

  sfw_watchdog #(.PRESCALE(P), .WAKE_SHORT(8), .WAKE_LONG(40)) sfw_watchdog_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .halt_req(halt_req),
    .wake_irq(wake_irq), .wake_long_sel(wls), .halt_enter(hen), .dev_reset_n(drn));

  // Free clock and a cycle count used to align sample points.
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Device reset is modelled by the bench, since the pulse does not reset the block.
  task automatic dev_rst();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // Handshakes are judged at the falling edge, where everything is settled.
  // Response ready is raised by every call and never lowered, so it stays high between back-to-back calls.
  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    logic ta, tw, pend;
    awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    pend = 1'b1;
    for (int i = 0; i < 50 && pend; i++) begin
      @(negedge aclk);
      ta = awv & awr; tw = wv & wr_rdy; pend = !(bv & br);
      if (!pend) chk({30'h0, bresp}, {30'h0, SFW_RESP_OKAY});
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    if (pend) begin n_mismatch++; summarize(); end
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] s);
    logic ta, pend;
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    pend = 1'b1;
    for (int i = 0; i < 50 && pend; i++) begin
      @(negedge aclk);
      ta = arv & arr; pend = !(rv & rr);
      if (!pend) begin v = rd; s = rresp; end
      @(posedge aclk);
      if (ta) arv <= 1'b0;
    end
    if (pend) begin n_mismatch++; summarize(); end
  endtask

  // Cycles until the reset output falls, then how long it stays low.
  task automatic rst_pulse(input int lim);
    t = 0; w = 0;
    do begin @(negedge aclk); t++; end while (drn === 1'b1 && t < lim);
    while (drn === 1'b0 && w < 100) begin @(negedge aclk); w++; end
    @(posedge aclk);
  endtask

  task automatic halt_pulse();
    halt_req <= 1'b1;
    @(posedge aclk);
    halt_req <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    {awv, wv, br, arv, rr, halt_req, wake_irq, wls} = '0;
    awa = '0; ara = '0; wd = '0; aresetn = 1'b0;
    n_mismatch = 0; compares = 0;
    dev_rst();
    // Reset value, then four prescaler periods give exactly four decrements.
    c0 = cyc; axr(SFW_CTRL_ADDR, d, r); c0 = cyc - c0;
    chk(d, 32'h7F);
    chk({30'h0, r}, {30'h0, SFW_RESP_OKAY});
    repeat (4 * P - c0) @(posedge aclk);
    axr(SFW_CTRL_ADDR, d1, r);
    chk(d - d1, 32'h4);
    // Inactive watchdog passes 40h to 3Fh with no reset.
    axw(SFW_CTRL_ADDR, 32'h41);
    rst_pulse(3 * P);
    chk(w, 0);
    axr(SFW_CTRL_ADDR, d, r);
    chk({30'h0, d[7:6]}, 32'h0);
    $display("test free count done");
    // Active timeout from 43h; an attempt to clear activate is ignored.
    axw(SFW_CTRL_ADDR, 32'hC3);
    // Refreshes spaced well inside the shortest timeout keep the device alive.
    for (int i = 0; i < 3; i++) begin
      rst_pulse(2 * P);
      chk(w, 0);
      axw(SFW_CTRL_ADDR, 32'hC3);
    end
    axw(SFW_CTRL_ADDR, 32'h43);
    axr(SFW_CTRL_ADDR, d, r);
    chk({31'h0, d[7]}, 32'h1);
    rst_pulse(6 * P);
    chk({31'h0, t >= 3 * P - 4 && t <= 4 * P + 4}, 32'h1);
    chk(w, SFW_RST_CYC);
    dev_rst();
    axr(SFW_CTRL_ADDR, d, r);
    chk({31'h0, d[7]}, 32'h0);
    $display("test timeout done");
    // Software reset and halt while active.
    axw(SFW_CTRL_ADDR, 32'h80);
    rst_pulse(8);
    chk(w, SFW_RST_CYC);
    dev_rst();
    axw(SFW_CTRL_ADDR, 32'hFF);
    halt_pulse();
    rst_pulse(8);
    chk(w, SFW_RST_CYC);
    dev_rst();
    $display("test forced reset done");
    // Halt while inactive: halt is entered, the count freezes, a wake restarts it.
    halt_pulse();
    for (k = 0; k < 8 && hen !== 1'b1; k++) @(negedge aclk);
    chk({31'h0, k < 8}, 32'h1);
    rst_pulse(2 * P);
    chk(w, 0);
    axr(SFW_CTRL_ADDR, d1, r);
    chk(d1, 32'h7E);
    repeat (2 * P) @(posedge aclk);
    axr(SFW_CTRL_ADDR, d2, r);
    chk(d2, d1);
    wake_irq <= 1'b1;
    @(posedge aclk);
    wake_irq <= 1'b0;
    repeat (8 + 3 * P) @(posedge aclk);
    axr(SFW_CTRL_ADDR, d, r);
    chk({31'h0, d[6:0] < d2[6:0]}, 32'h1);
    dev_rst();
    // Long wake selection keeps the count frozen well past the short delay.
    wls <= 1'b1;
    halt_pulse();
    repeat (2 * P) @(posedge aclk);
    wake_irq <= 1'b1;
    @(posedge aclk);
    wake_irq <= 1'b0;
    repeat (24) @(posedge aclk);
    axr(SFW_CTRL_ADDR, d, r);
    chk(d, 32'h7E);
    repeat (40 + 2 * P) @(posedge aclk);
    axr(SFW_CTRL_ADDR, d, r);
    chk({31'h0, d[6:0] < 7'h7E}, 32'h1);
    wls <= 1'b0;
    dev_rst();
    $display("test halt done");
    // Options: hardware watchdog forces activate; halt-reset option resets on halt.
    axw(SFW_OPT_ADDR, 32'h1);
    axr(SFW_CTRL_ADDR, d, r);
    chk({31'h0, d[7]}, 32'h1);
    dev_rst();
    axw(SFW_OPT_ADDR, 32'h2);
    halt_pulse();
    rst_pulse(8);
    chk(w, SFW_RST_CYC);
    dev_rst();
    // Unmapped address is refused with an error and zero data.
    axr(4'hC, d, r);
    chk({30'h0, r}, {30'h0, SFW_RESP_SLVERR});
    chk(d, 32'h0);
    $display("test options done");
    summarize();
  end

  // A hang anywhere ends the run as a failure.
  initial begin
    repeat (100000) @(posedge aclk);
    n_mismatch++;
    summarize();
  end
endmodule
